/* logic/ptmr_pkg.sv */
package ptmr_pkg;
  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ptmr_apb_t;
  // Whole state of the timer.
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [9:0]  cmp_a;
    logic [9:0]  cmp_p;
    logic [9:0]  cnt;
    logic [5:0]  pre;
    logic        on_d;
    logic        sub_s1;
    logic        sub_s2;
    logic        sub_d;
    logic        fa;
    logic        fp;
    logic        pin;
    logic        pin_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ptmr_state_t;
endpackage

/* logic/ptmr_regs.svh */
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH
// Byte offsets of the registers on APB.
`define PTMR_OFF_CTRL0  8'h00
`define PTMR_OFF_CTRL1  8'h04
`define PTMR_OFF_CNT_L  8'h08
`define PTMR_OFF_CNT_H  8'h0c
`define PTMR_OFF_CMPA_L 8'h10
`define PTMR_OFF_CMPA_H 8'h14
`define PTMR_OFF_CMPP_L 8'h18
`define PTMR_OFF_CMPP_H 8'h1c
`define PTMR_OFF_FLAGS  8'h20
// Reset values.
`define PTMR_RST_CTRL 8'h00
`define PTMR_RST_CMP  10'h000
// Field positions of the first control register.
`define PTMR_B_PAUSE 7
`define PTMR_B_CKH   6
`define PTMR_B_CKL   4
`define PTMR_B_ON    3
// Field positions of the second control register.
`define PTMR_B_MODEH 7
`define PTMR_B_MODEL 6
`define PTMR_B_PIOH  5
`define PTMR_B_PIOL  4
`define PTMR_B_OC    3
`define PTMR_B_POL   2
`define PTMR_B_CCS   0
// Flag register fields.
`define PTMR_B_FA 0
`define PTMR_B_FP 1
// Mode codes.
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TC  2'h3
// Prescaler terminal counts.
`define PTMR_DIV4  6'h03
`define PTMR_DIV16 6'h0f
`define PTMR_DIV64 6'h3f
`endif

/* logic/ptmr_top.sv */
`timescale 1ns/1ps
`include "ptmr_regs.svh"
module ptmr_top #(
  parameter int CNT_W = 10
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire ptmr_pkg::ptmr_apb_t apb,
  input  wire logic              sub_clk_in,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   timer_output_pin,
  output logic                   timer_output_oe,
  output logic                   match_a_flag,
  output logic                   match_p_flag
);

  // ****************************************
  // Parameter check
  // ****************************************

  // The register map holds exactly ten counter bits.
  if (CNT_W != 10) begin : g_bad_width
    $error("ptmr_top supports only a ten-bit counter");
  end

  // ****************************************
  // State
  // ****************************************

  ptmr_pkg::ptmr_state_t st;       // Registered state.
  ptmr_pkg::ptmr_state_t next_st;  // Next state.

  // Decoded control fields and derived internal signals.
  logic       on_bit;    // Counter enable.
  logic       pause;     // Counter pause.
  logic [2:0] ck_sel;    // Clock source code.
  logic [1:0] mode;      // Operating mode.
  logic [1:0] pio;       // Pin function code.
  logic       oc;        // Initial or active level.
  logic       pol;       // Output inversion.
  logic       ccs;       // Clear source select.
  logic       on_rise;   // counter_on went high.
  logic       tick;      // One counter clock.
  logic       sub_tick;  // Sub clock rising edge.
  logic [9:0] inc;       // Counter plus one.
  logic       hit_a;     // Comparator A match.
  logic       hit_p;     // Comparator P match.
  logic       run;       // Counter may advance.
  logic       wr;        // APB write access.
  logic       setup;     // APB setup phase.
  logic       sp_mode;   // Single-pulse mode.
  logic       pwm_act;   // PWM waveform level.
  logic       lvl;       // Pin level before invert.

  // ****************************************
  // Field decode
  // ****************************************

  // Pull the fields out of the control registers.
  always_comb begin
    on_bit  = st.ctrl0[`PTMR_B_ON];
    pause   = st.ctrl0[`PTMR_B_PAUSE];
    ck_sel  = st.ctrl0[`PTMR_B_CKH:`PTMR_B_CKL];
    mode    = st.ctrl1[`PTMR_B_MODEH:`PTMR_B_MODEL];
    pio     = st.ctrl1[`PTMR_B_PIOH:`PTMR_B_PIOL];
    oc      = st.ctrl1[`PTMR_B_OC];
    pol     = st.ctrl1[`PTMR_B_POL];
    ccs     = st.ctrl1[`PTMR_B_CCS];
    on_rise = on_bit & ~st.on_d;
    sp_mode = (mode == `PTMR_MODE_PWM) & (pio == 2'h3);
    wr      = apb.psel & apb.penable & apb.pwrite;
    setup   = apb.psel & ~apb.penable;
  end

  // ****************************************
  // Clock source select
  // ****************************************

  // The sub clock arrives from a pin, so only the
  // second sync stage feeds the edge detector.
  always_comb begin
    sub_tick = st.sub_s2 & ~st.sub_d;
    case (ck_sel)
      3'h0:       tick = ((st.pre & `PTMR_DIV4) == `PTMR_DIV4);
      3'h1:       tick = 1'b1;
      3'h2:       tick = ((st.pre & `PTMR_DIV16) == `PTMR_DIV16);
      3'h3:       tick = (st.pre == `PTMR_DIV64);
      3'h4, 3'h5: tick = sub_tick;
      default: begin
        // Reserved codes give no counter clock.
        tick = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Comparators
  // ****************************************

  // A match means the next count would equal the
  // compare value; a P value of zero stands for the wrap at 3FF, an A value of zero never matches.
  always_comb begin
    inc   = st.cnt + 10'h001;
    hit_a = (inc == st.cmp_a) & (st.cmp_a != 10'h000);
    hit_p = (inc == st.cmp_p);
    run   = on_bit & ~pause & ~on_rise & tick;
    // Duty at or above the period keeps it active.
    pwm_act = (st.cnt < st.cmp_a);
  end

  // ****************************************
  // Next state
  // ****************************************

  // Counter, flags, pin and APB slave in one place.
  always_comb begin
    next_st = st;
    // Free-running prescaler and sub clock sync.
    next_st.pre    = st.pre + 6'h01;
    next_st.sub_s1 = sub_clk_in;
    next_st.sub_s2 = st.sub_s1;
    next_st.sub_d  = st.sub_s2;
    next_st.on_d   = on_bit;

    // Counting.
    if (on_rise) begin
      next_st.cnt = 10'h000;
    end else if (run) begin
      if (mode == `PTMR_MODE_PWM) begin
        // Clear select is not looked at here.
        if (sp_mode) begin
          next_st.cnt = inc;
        end else if (hit_p) begin
          next_st.cnt = 10'h000;
        end else begin
          next_st.cnt = inc;
        end
      end else if (ccs ? hit_a : hit_p) begin
        next_st.cnt = 10'h000;
      end else begin
        next_st.cnt = inc;
      end
    end
    // Otherwise off, paused or no tick: hold.

    // Flags; a set in the clear cycle wins.
    if (wr & (apb.paddr == `PTMR_OFF_FLAGS)) begin
      if (apb.pwdata[`PTMR_B_FA]) begin
        next_st.fa = 1'b0;
      end
      if (apb.pwdata[`PTMR_B_FP]) begin
        next_st.fp = 1'b0;
      end
    end
    if (run & hit_a) begin
      next_st.fa = 1'b1;
    end
    // P only flags when it clears the counter.
    if (run & hit_p & ~sp_mode) begin
      if ((mode == `PTMR_MODE_PWM) | ~ccs) begin
        next_st.fp = 1'b1;
      end
    end

    // Pin level before inversion.
    lvl = st.pin ^ pol;
    if (mode == `PTMR_MODE_PWM) begin
      case (pio)
        2'h0: begin
          lvl = ~oc;
        end
        2'h1: begin
          lvl = oc;
        end
        2'h2: begin
          lvl = pwm_act ? oc : ~oc;
        end
        default: begin
          // Active from the rise until counter_on falls.
          lvl = on_bit ? oc : ~oc;
        end
      endcase
      if (on_rise & (pio == 2'h2)) begin
        // The count restarts at zero, so show the level for zero.
        lvl = (st.cmp_a != 10'h000) ? oc : ~oc;
      end
    end else if (on_rise) begin
      lvl = oc;
    end else if (run & hit_a) begin
      // A level equal to the present one is no change.
      case (pio)
        2'h1: begin
          lvl = 1'b0;
        end
        2'h2: begin
          lvl = 1'b1;
        end
        2'h3: begin
          lvl = ~lvl;
        end
        default: begin
          lvl = lvl;
        end
      endcase
    end
    if (mode == `PTMR_MODE_TC) begin
      next_st.pin_oe = 1'b0;
      next_st.pin    = st.pin;
    end else begin
      next_st.pin_oe = 1'b1;
      next_st.pin    = lvl ^ pol;
    end

    // Single pulse ends at an A match.
    if (sp_mode & run & hit_a) begin
      next_st.ctrl0[`PTMR_B_ON] = 1'b0;
    end

    // APB writes take effect in the access phase.
    if (wr) begin
      case (apb.paddr)
        `PTMR_OFF_CTRL0: begin
          next_st.ctrl0 = {apb.pwdata[7:3], 3'h0};
        end
        `PTMR_OFF_CTRL1: begin
          next_st.ctrl1 = apb.pwdata[7:0];
        end
        `PTMR_OFF_CMPA_L: begin
          next_st.cmp_a[7:0] = apb.pwdata[7:0];
        end
        `PTMR_OFF_CMPA_H: begin
          next_st.cmp_a[9:8] = apb.pwdata[1:0];
        end
        `PTMR_OFF_CMPP_L: begin
          next_st.cmp_p[7:0] = apb.pwdata[7:0];
        end
        `PTMR_OFF_CMPP_H: begin
          next_st.cmp_p[9:8] = apb.pwdata[1:0];
        end
        default: begin
          // Counter bytes have no write path.
          next_st.ctrl1 = st.ctrl1;
        end
      endcase
    end

    // Read data and error are formed in setup.
    next_st.pready = 1'b1;
    if (setup) begin
      next_st.pslverr = 1'b0;
      case (apb.paddr)
        `PTMR_OFF_CTRL0: begin
          next_st.prdata = {24'h0, st.ctrl0};
        end
        `PTMR_OFF_CTRL1: begin
          next_st.prdata = {24'h0, st.ctrl1};
        end
        `PTMR_OFF_CNT_L: begin
          next_st.prdata = {24'h0, st.cnt[7:0]};
        end
        `PTMR_OFF_CNT_H: begin
          next_st.prdata = {30'h0, st.cnt[9:8]};
        end
        `PTMR_OFF_CMPA_L: begin
          next_st.prdata = {24'h0, st.cmp_a[7:0]};
        end
        `PTMR_OFF_CMPA_H: begin
          next_st.prdata = {30'h0, st.cmp_a[9:8]};
        end
        `PTMR_OFF_CMPP_L: begin
          next_st.prdata = {24'h0, st.cmp_p[7:0]};
        end
        `PTMR_OFF_CMPP_H: begin
          next_st.prdata = {30'h0, st.cmp_p[9:8]};
        end
        `PTMR_OFF_FLAGS: begin
          next_st.prdata = {30'h0, st.fp, st.fa};
        end
        default: begin
          next_st.prdata  = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Constant reset values only.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st        <= '0;
      st.ctrl0  <= `PTMR_RST_CTRL;
      st.ctrl1  <= `PTMR_RST_CTRL;
      st.cmp_a  <= `PTMR_RST_CMP;
      st.cmp_p  <= `PTMR_RST_CMP;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops.
  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign timer_output_pin = st.pin;
  assign timer_output_oe  = st.pin_oe;
  assign match_a_flag     = st.fa;
  assign match_p_flag     = st.fp;

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_cnt_zero_rise: assert property (
    on_rise |=> st.cnt == 10'h000)
    else $error("counter not zeroed on enable rise");
  a_pause_hold: assert property (
    on_bit & pause & ~on_rise |=> $stable(st.cnt))
    else $error("counter moved while paused");
  a_off_hold: assert property (
    ~on_bit |=> st.cnt == $past(st.cnt))
    else $error("counter moved while off");
  a_tc_pin_off: assert property (
    mode == `PTMR_MODE_TC |=> ~timer_output_oe)
    else $error("pin driven in timer mode");
  a_rsv_zero: assert property (
    st.ctrl0[2:0] == 3'h0)
    else $error("reserved control bits not zero");
  a_init_level: assert property (
    on_rise & mode == `PTMR_MODE_CMP
      |=> timer_output_pin == ($past(oc) ^ $past(pol)))
    else $error("pin not at initial level");
  a_ccs_no_fp: assert property (
    mode == `PTMR_MODE_CMP & ccs & ~match_p_flag
      |=> ~match_p_flag)
    else $error("P flag raised with A clearing");
  a_sp_auto_off: assert property (
    sp_mode & run & hit_a & ~wr |=> ~on_bit ##1 ~st.on_d)
    else $error("single pulse did not end");
  a_clear_on_a: assert property (
    mode == `PTMR_MODE_CMP & ccs & run & hit_a
      |=> st.cnt == 10'h000 && match_a_flag)
    else $error("A match did not clear counter");

  c_cmp_match: cover property (
    mode == `PTMR_MODE_CMP & run & hit_a);
  c_pwm_period: cover property (
    mode == `PTMR_MODE_PWM & ~sp_mode & run & hit_p);
  c_single_end: cover property (
    sp_mode & run & hit_a);

endmodule

/* tb/test_periodic_timer_10bit.sv */
`timescale 1ns/1ps
`include "ptmr_regs.svh"
module test_periodic_timer_10bit;
  // ******
  // Signals
  // ******
  logic                core_clk;          // Bench clock, 40 ns.
  logic                sys_rst;           // Asynchronous reset, active high.
  ptmr_pkg::ptmr_apb_t apb;               // Request driven by the bench master.
  logic                sub_clk_in;        // Slow clock for the sub clock source.
  logic [31:0]         prdata;            // Read data from the block.
  logic                pready;            // Slave ready.
  logic                pslverr;           // Slave error.
  logic                timer_output_pin;  // Pin level.
  logic                timer_output_oe;   // Pin driven.
  logic                match_a_flag;      // Sticky A flag.
  logic                match_p_flag;      // Sticky P flag.
  logic                s_err;             // Error taken with the read data.
  logic [1:0]          sub_cnt;           // Divider for the sub clock.
  logic [31:0]         q;                 // Last read word.
  logic [31:0]         q2;                // Second read word.
  int                  n_fail;            // Mismatches seen.
  int                  total_checks;      // Comparisons made.
  int                  k;                 // Cycle counter of waits.
  int                  n;                 // Active cycle count.
  // Ordinary register rows: address, written byte, byte read back.
  logic [7:0] r_adr [9] = '{`PTMR_OFF_CTRL0, `PTMR_OFF_CTRL1, `PTMR_OFF_CTRL1,
    `PTMR_OFF_CMPA_L, `PTMR_OFF_CMPA_H, `PTMR_OFF_CMPP_L, `PTMR_OFF_CMPP_H,
    `PTMR_OFF_CNT_L, `PTMR_OFF_CNT_H};
  logic [7:0] r_wr [9] = '{8'h07, 8'hdd, 8'h00, 8'ha5, 8'hff, 8'h5a, 8'hfe, 8'hff, 8'hff};
  logic [7:0] r_ex [9] = '{8'h00, 8'hdd, 8'h00, 8'ha5, 8'h03, 8'h5a, 8'h02, 8'h00, 8'h00};
  // Clock rows: source code and the window of ticks in about 130 cycles.
  logic [2:0] c_code [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h1};
  int         c_lo   [7] = '{29, 7, 1, 14, 0, 0, 124};
  int         c_hi   [7] = '{35, 10, 3, 18, 0, 0, 134};
  // Waveform rows: pin function, duty, active cycles in 16 with period 8.
  logic [1:0] w_pio  [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
  logic [9:0] w_duty [4] = '{10'h003, 10'h00a, 10'h003, 10'h003};
  int         w_hi   [4] = '{6, 16, 16, 0};

  ptmr_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .apb(apb), .sub_clk_in(sub_clk_in),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag));

  // ******
  // Clock and sub clock
  // ******
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // The sub clock toggles every four cycles, so it rises once in eight.
  always @(posedge core_clk) begin
    sub_cnt <= sub_cnt + 2'h1;
    if (sub_cnt == 2'h3) begin
      sub_clk_in <= ~sub_clk_in;
    end
  end

  // ******
  // Tasks
  // ******
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until ready is seen at an edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    i = 0;
    // Outputs read at the edge still show what stood before it.
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      stop_test();
    end else begin
      q           = prdata;
      s_err       = pslverr;
      apb.psel    <= 1'b0;
      apb.penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  // Writes a ten-bit compare value as its two bytes.
  task automatic setc(input logic [7:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, {6'h0, v[9:8]});
  endtask
  // Waits for a flag, counting cycles; a missing flag ends the run.
  task automatic waitf(input bit sel_p);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while ((sel_p ? match_p_flag : match_a_flag) !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  // ******
  // Main sequence
  // ******
  initial begin
    n_fail = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    apb = '0;
    sub_clk_in = 1'b0;
    sub_cnt = 2'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(timer_output_oe, 1'b1);
    xfer(1'b0, `PTMR_OFF_CTRL1, 0);
    chk(q, 0);
    xfer(1'b0, 8'h40, 0);
    chk(q, 32'h0);
    chk(s_err, 1'b1);
    endt("reset");
    // Register table rows.
    for (int r = 0; r < 9; r++) begin
      wr(r_adr[r], r_wr[r]);
      xfer(1'b0, r_adr[r], 0);
      chk(q, {24'h0, r_ex[r]});
    end
    endt("registers");
    // Compare mode, P clears: A flag then P flag three cycles later.
    setc(`PTMR_OFF_CMPA_L, 10'h005);
    setc(`PTMR_OFF_CMPP_L, 10'h008);
    wr(`PTMR_OFF_CTRL1, 8'h30);
    wr(`PTMR_OFF_FLAGS, 8'h03);
    wr(`PTMR_OFF_CTRL0, 8'h18);
    waitf(1'b0);
    chk(timer_output_pin, 1'b1);
    waitf(1'b1);
    chk(k, 3);
    endt("compare");
    // Every pin function with both polarities; A clears, so no P flag
    // even though P lies below A and is passed on every count.
    setc(`PTMR_OFF_CMPP_L, 10'h003);
    for (int p = 0; p < 8; p++) begin
      wr(`PTMR_OFF_CTRL0, 8'h10);
      wr(`PTMR_OFF_CTRL1, {2'h0, p[2:1], 1'b0, p[0], 2'h1});
      wr(`PTMR_OFF_FLAGS, 8'h03);
      wr(`PTMR_OFF_CTRL0, 8'h18);
      repeat (3) @(posedge core_clk);
      chk(timer_output_pin, p[0]);
      waitf(1'b0);
      chk(timer_output_pin, p[2] ^ p[0]);
      repeat (20) @(posedge core_clk);
      chk(match_p_flag, 1'b0);
    end
    endt("pin functions");
    // Timer mode releases the pin; each clock source is timed.
    wr(`PTMR_OFF_CTRL0, 8'h10);
    wr(`PTMR_OFF_CTRL1, 8'hc0);
    setc(`PTMR_OFF_CMPP_L, 10'h000);
    chk(timer_output_oe, 1'b0);
    for (int c = 0; c < 7; c++) begin
      wr(`PTMR_OFF_CTRL0, 8'h00);
      wr(`PTMR_OFF_CTRL0, {1'b0, c_code[c], 4'h8});
      repeat (128) @(posedge core_clk);
      wr(`PTMR_OFF_CTRL0, {1'b1, c_code[c], 4'h8});
      xfer(1'b0, `PTMR_OFF_CNT_L, 0);
      chk(q >= c_lo[c] && q <= c_hi[c], 1'b1);
      q2 = q;
      repeat (8) @(posedge core_clk);
      xfer(1'b0, `PTMR_OFF_CNT_L, 0);
      chk(q, q2);
    end
    // Resume from the held count, then stop and keep it.
    wr(`PTMR_OFF_CTRL0, 8'h18);
    repeat (4) @(posedge core_clk);
    wr(`PTMR_OFF_CTRL0, 8'h10);
    xfer(1'b0, `PTMR_OFF_CNT_L, 0);
    chk(q > q2 && q < q2 + 12, 1'b1);
    q2 = q;
    repeat (8) @(posedge core_clk);
    xfer(1'b0, `PTMR_OFF_CNT_L, 0);
    chk(q, q2);
    wr(`PTMR_OFF_CTRL0, 8'h18);
    xfer(1'b0, `PTMR_OFF_CNT_L, 0);
    chk(q < 8, 1'b1);
    endt("clock sources");
    // Waveform rows, period 8, active high.
    setc(`PTMR_OFF_CMPP_L, 10'h008);
    for (int w = 0; w < 4; w++) begin
      wr(`PTMR_OFF_CTRL0, 8'h10);
      wr(`PTMR_OFF_CTRL1, {2'h2, w_pio[w], 4'h8});
      setc(`PTMR_OFF_CMPA_L, w_duty[w]);
      wr(`PTMR_OFF_FLAGS, 8'h03);
      wr(`PTMR_OFF_CTRL0, 8'h18);
      repeat (4) @(posedge core_clk);
      n = 0;
      repeat (16) begin
        @(posedge core_clk);
        #1;
        n += int'(timer_output_pin === 1'b1);
      end
      chk(n, w_hi[w]);
      // A duty beyond the period never matches, so A stays quiet then.
      chk({match_a_flag, match_p_flag}, {w_duty[w] < 10'h008, 1'b1});
    end
    endt("waveform");
    // Single pulse: A match ends the pulse and turns the counter off.
    wr(`PTMR_OFF_CTRL0, 8'h10);
    wr(`PTMR_OFF_CTRL1, 8'hb8);
    setc(`PTMR_OFF_CMPA_L, 10'h006);
    wr(`PTMR_OFF_FLAGS, 8'h03);
    wr(`PTMR_OFF_CTRL0, 8'h18);
    repeat (3) @(posedge core_clk);
    chk(timer_output_pin, 1'b1);
    waitf(1'b0);
    repeat (2) @(posedge core_clk);
    chk(timer_output_pin, 1'b0);
    xfer(1'b0, `PTMR_OFF_CTRL0, 0);
    chk(q[3], 1'b0);
    endt("single pulse");
    // Reset in mid-run clears outputs and registers.
    wr(`PTMR_OFF_CTRL0, 8'h18);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({pready, timer_output_pin, timer_output_oe, match_a_flag, match_p_flag}, 0);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    xfer(1'b0, `PTMR_OFF_CMPA_L, 0);
    chk(q, 0);
    endt("second reset");
    stop_test();
  end
endmodule
